// >>> design/ascr_pkg.sv
// Package: register map, field positions and timing counts of the config port
package ascr_pkg;
    // ------------------------------------------------------------------
    // Serial word layout
    // ------------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int ADDR_BITS = 5;
    localparam int DATA_BITS = 11;
    localparam int CNT_BITS = 4;
    // ------------------------------------------------------------------
    // Register addresses on the serial port
    // ------------------------------------------------------------------
    localparam logic [4:0] REG_MAIN_CONTROL = 5'h00;
    localparam logic [4:0] REG_OUTPUT_CLOCK_PLACEMENT = 5'h04;
    localparam logic [4:0] REG_LANE_ORDERING = 5'h09;
    localparam logic [4:0] REG_FORMAT_AND_PATTERN = 5'h0A;
    localparam logic [4:0] REG_USER_PATTERN_LOW = 5'h0B;
    localparam logic [4:0] REG_TRIM_GAIN_AND_PATTERN_HIGH = 5'h0C;
    localparam logic [4:0] REG_DIFFERENTIAL_OUTPUT_SETUP = 5'h0E;
    localparam logic [4:0] REG_SINGLE_ENDED_DRIVE_SETUP = 5'h0F;
    localparam int NUM_REGS = 8;
    // ------------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------------
    localparam int MC_STANDBY = 0;
    localparam int MC_CLK_PDN = 2;
    localparam int MC_SOFT_INIT = 4;
    localparam int MC_REF_SEL = 5;
    localparam int MC_OUT_STYLE = 8;
    localparam int MC_COARSE_GAIN = 9;
    localparam int MC_OBUF_PDN = 10;
    localparam int FP_PATTERN_LSB = 5;
    localparam int FP_NUM_FORMAT = 10;
    localparam logic [10:0] MASK_MAIN = 11'h735;
    localparam logic [10:0] MASK_CLKPOS = 11'h700;
    localparam logic [10:0] MASK_LANE = 11'h400;
    localparam logic [10:0] MASK_FMT = 11'h4E0;
    localparam logic [10:0] MASK_FULL = 11'h7FF;
    localparam logic [10:0] REG_RESET = 11'h000;
    // ------------------------------------------------------------------
    // Test pattern codes
    // ------------------------------------------------------------------
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_ZEROS = 3'h1;
    localparam logic [2:0] PAT_ONES = 3'h2;
    localparam logic [2:0] PAT_TOGGLE = 3'h3;
    localparam logic [13:0] TOGGLE_A = 14'h2AAA;
    localparam logic [13:0] TOGGLE_B = 14'h1555;
    // ------------------------------------------------------------------
    // Timing, 100 MHz clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESET_PULSE_NS = 10;
    localparam int RESET_PULSE_CYC =
        (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int WRITE_DELAY_NS = 25;
    localparam int WRITE_DELAY_CYC =
        (WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_ON_MS = 5;
    localparam int POWER_ON_CYC = POWER_ON_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SHIFT_HALF_NS = 50;
    localparam int SHIFT_HALF_CYC = SHIFT_HALF_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------------
    // Host register map on AHB-Lite
    // ------------------------------------------------------------------
    localparam logic [7:0] HOST_CTRL = 8'h00;
    localparam logic [7:0] HOST_WORD = 8'h04;
    localparam logic [7:0] HOST_STATUS = 8'h08;
    localparam int HC_START = 0;
    localparam int HC_HW_RESET = 1;
    localparam int HC_PARALLEL = 2;
    localparam int HS_BUSY = 0;
    localparam int HS_RESET_DONE = 1;
    localparam int HS_WORDS_LSB = 8;
endpackage : ascr_pkg

// >>> design/ascr_if.sv
// Interface: three-wire serial configuration link plus reset pin
`timescale 1ns/100ps
interface ascr_if;
    logic reset_pin;
    logic serial_select_low;
    logic shift_clock;
    logic shift_data_line;
    modport device (
        input reset_pin,
        input serial_select_low,
        input shift_clock,
        input shift_data_line
    );
    modport host (
        output reset_pin,
        output serial_select_low,
        output shift_clock,
        output shift_data_line
    );
endinterface : ascr_if

// >>> design/ascr_device.sv
// Device end: serial shift register and configuration register bank
//
// Functional notes
// - High reset pulse over 10 ns loads defaults
// - Soft init bit loads defaults, then clears
// - Host holds reset low during soft init
// - Host waits 5 ms after power before reset
// - Host waits 25 ns after reset before select
// - Parallel control keeps reset pin high
// - Host writes zero to unassigned bits
// - One write updates all register fields together
// - Reg 00 holds obuf, gain, style, ref
// - Reg 00 soft init, clock pdn, standby
// - Reg 04 data position and clock edge
// - Reg 04 clock position in D8
// - Reg 0A number format select in D10
// - Word is five address, eleven data bits
// - Sample on falling edge, commit every 16th
// - Standby powers core; style picks DDR/parallel
// - Reg 0A pattern field selects output source
`timescale 1ns/100ps
module ascr_device (
    input wire logic hclk,
    input wire logic hresetn,
    ascr_if.device link,
    output logic standby,
    output logic clk_out_pdn,
    output logic ref_external,
    output logic ddr_outputs,
    output logic coarse_gain,
    output logic obuf_pdn,
    output logic data_pos_late,
    output logic clk_capture_fall,
    output logic clk_pos_delay,
    output logic lane_bytewise,
    output logic straight_binary,
    output logic [2:0] pattern_sel,
    output logic [13:0] pattern_word,
    output logic [10:0] user_pattern_lo,
    output logic [10:0] trim_gain_pattern_hi,
    output logic [10:0] diff_output_setup,
    output logic [10:0] se_drive_setup
);
    // ------------------------------------------------------------------
    // Pin edges and reset handling
    // ------------------------------------------------------------------
    logic clk_d;
    logic reset_d;
    logic sclk_fall;
    logic [ascr_pkg::CNT_BITS-1:0] bit_cnt;
    logic [ascr_pkg::WORD_BITS-2:0] shreg;
    logic [ascr_pkg::WORD_BITS-1:0] word;
    logic commit;
    logic init_all;
    logic soft_init;
    logic [10:0] r_main;
    logic [10:0] r_clkpos;
    logic [10:0] r_lane;
    logic [10:0] r_fmt;
    logic [10:0] r_plo;
    logic [10:0] r_phi;
    logic [10:0] r_diff;
    logic [10:0] r_se;
    logic toggle_ph;

    // Previous levels of shift clock and reset pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_d <= 1'b0;
            reset_d <= 1'b0;
        end else begin
            clk_d <= link.shift_clock;
            reset_d <= link.reset_pin;
        end
    end

    assign sclk_fall = clk_d && !link.shift_clock;
    // Defaults load on the pin's falling edge so any pulse width counts
    assign init_all = (reset_d && !link.reset_pin) || soft_init;

    // ------------------------------------------------------------------
    // Serial shifter
    // ------------------------------------------------------------------
    // Bit count and shift; select high clears any partial word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt <= '0;
            shreg <= '0;
        end else if (link.serial_select_low || link.reset_pin) begin
            bit_cnt <= '0;
        end else if (sclk_fall) begin
            shreg <= {shreg[ascr_pkg::WORD_BITS-3:0], link.shift_data_line};
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    assign commit = !link.serial_select_low && !link.reset_pin
        && sclk_fall && (bit_cnt == 4'hF);
    assign word = {shreg, link.shift_data_line};

    // ------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------
    // Whole-register writes; unmapped addresses fall through
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_main <= ascr_pkg::REG_RESET;
            r_clkpos <= ascr_pkg::REG_RESET;
            r_lane <= ascr_pkg::REG_RESET;
            r_fmt <= ascr_pkg::REG_RESET;
            r_plo <= ascr_pkg::REG_RESET;
            r_phi <= ascr_pkg::REG_RESET;
            r_diff <= ascr_pkg::REG_RESET;
            r_se <= ascr_pkg::REG_RESET;
        end else if (init_all) begin
            r_main <= ascr_pkg::REG_RESET;
            r_clkpos <= ascr_pkg::REG_RESET;
            r_lane <= ascr_pkg::REG_RESET;
            r_fmt <= ascr_pkg::REG_RESET;
            r_plo <= ascr_pkg::REG_RESET;
            r_phi <= ascr_pkg::REG_RESET;
            r_diff <= ascr_pkg::REG_RESET;
            r_se <= ascr_pkg::REG_RESET;
        end else if (commit) begin
            unique case (word[15:11])
                ascr_pkg::REG_MAIN_CONTROL:
                    r_main <= word[10:0] & ascr_pkg::MASK_MAIN;
                ascr_pkg::REG_OUTPUT_CLOCK_PLACEMENT:
                    r_clkpos <= word[10:0] & ascr_pkg::MASK_CLKPOS;
                ascr_pkg::REG_LANE_ORDERING:
                    r_lane <= word[10:0] & ascr_pkg::MASK_LANE;
                ascr_pkg::REG_FORMAT_AND_PATTERN:
                    r_fmt <= word[10:0] & ascr_pkg::MASK_FMT;
                ascr_pkg::REG_USER_PATTERN_LOW:
                    r_plo <= word[10:0];
                ascr_pkg::REG_TRIM_GAIN_AND_PATTERN_HIGH:
                    r_phi <= word[10:0];
                ascr_pkg::REG_DIFFERENTIAL_OUTPUT_SETUP:
                    r_diff <= word[10:0];
                ascr_pkg::REG_SINGLE_ENDED_DRIVE_SETUP:
                    r_se <= word[10:0];
                default: ;
            endcase
        end
    end

    // Soft init bit acts one cycle after its write, then reads zero
    assign soft_init = r_main[ascr_pkg::MC_SOFT_INIT];

    // ------------------------------------------------------------------
    // Decoded outputs
    // ------------------------------------------------------------------
    // Toggle pattern phase advances each clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            toggle_ph <= 1'b0;
        end else begin
            toggle_ph <= !toggle_ph;
        end
    end

    // Registered control outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            standby <= 1'b0;
            clk_out_pdn <= 1'b0;
            ref_external <= 1'b0;
            ddr_outputs <= 1'b0;
            coarse_gain <= 1'b0;
            obuf_pdn <= 1'b0;
            data_pos_late <= 1'b0;
            clk_capture_fall <= 1'b0;
            clk_pos_delay <= 1'b0;
            lane_bytewise <= 1'b0;
            straight_binary <= 1'b0;
            pattern_sel <= 3'h0;
            pattern_word <= 14'h0000;
            user_pattern_lo <= 11'h000;
            trim_gain_pattern_hi <= 11'h000;
            diff_output_setup <= 11'h000;
            se_drive_setup <= 11'h000;
        end else begin
            standby <= r_main[ascr_pkg::MC_STANDBY];
            clk_out_pdn <= r_main[ascr_pkg::MC_CLK_PDN];
            ref_external <= r_main[ascr_pkg::MC_REF_SEL];
            ddr_outputs <= r_main[ascr_pkg::MC_OUT_STYLE];
            coarse_gain <= r_main[ascr_pkg::MC_COARSE_GAIN];
            obuf_pdn <= r_main[ascr_pkg::MC_OBUF_PDN];
            data_pos_late <= r_clkpos[10];
            clk_capture_fall <= r_clkpos[9];
            clk_pos_delay <= r_clkpos[8];
            lane_bytewise <= r_lane[10];
            straight_binary <= r_fmt[ascr_pkg::FP_NUM_FORMAT];
            pattern_sel <= r_fmt[7:5];
            unique case (r_fmt[7:5])
                ascr_pkg::PAT_ZEROS: pattern_word <= 14'h0000;
                ascr_pkg::PAT_ONES: pattern_word <= 14'h3FFF;
                ascr_pkg::PAT_TOGGLE: pattern_word <= toggle_ph ?
                    ascr_pkg::TOGGLE_B : ascr_pkg::TOGGLE_A;
                default: pattern_word <= 14'h0000;
            endcase
            user_pattern_lo <= r_plo;
            trim_gain_pattern_hi <= r_phi;
            diff_output_setup <= r_diff;
            se_drive_setup <= r_se;
        end
    end
endmodule : ascr_device

// >>> design/ascr_host.sv
// Host end: AHB-Lite slave that drives the serial configuration link
`timescale 1ns/100ps
module ascr_host #(
    parameter int POWER_ON_CYCLES = ascr_pkg::POWER_ON_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    ascr_if.host link
);
    typedef enum logic [2:0] {
        ST_POWER = 3'b000,
        ST_IDLE = 3'b001,
        ST_RESET = 3'b010,
        ST_GAP = 3'b011,
        ST_LOW = 3'b100,
        ST_HIGH = 3'b101,
        ST_END = 3'b110
    } ascr_state_e;

    ascr_state_e state;
    logic [31:0] cnt;
    logic [4:0] bits;
    logic [15:0] word;
    logic parallel;
    logic reset_done;
    logic [7:0] words_sent;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic start_req;
    logic reset_req;

    // ------------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------------
    // Capture write address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            wr_addr <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite) begin
                unique case (haddr[7:0])
                    ascr_pkg::HOST_WORD: hrdata <= {16'h0000, word};
                    ascr_pkg::HOST_STATUS: hrdata <= {16'h0000,
                        words_sent, 6'h00, reset_done, state != ST_IDLE};
                    ascr_pkg::HOST_CTRL: hrdata <= {29'h0, parallel, 2'h0};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign start_req = wr_pend && wr_addr == ascr_pkg::HOST_CTRL
        && hwdata[ascr_pkg::HC_START];
    assign reset_req = wr_pend && wr_addr == ascr_pkg::HOST_CTRL
        && hwdata[ascr_pkg::HC_HW_RESET];

    // Ready and response constant
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Word and mode registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word <= 16'h0000;
            parallel <= 1'b0;
        end else if (wr_pend && wr_addr == ascr_pkg::HOST_WORD) begin
            word <= hwdata[15:0]; // software supplies zero fill
        end else if (wr_pend && wr_addr == ascr_pkg::HOST_CTRL) begin
            parallel <= hwdata[ascr_pkg::HC_PARALLEL];
        end else if (state == ST_HIGH && cnt == 32'h0) begin
            word <= {word[14:0], 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // Link sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_POWER;
            cnt <= 32'h0;
            bits <= 5'h00;
            reset_done <= 1'b0;
            words_sent <= 8'h00;
            link.reset_pin <= 1'b0;
            link.serial_select_low <= 1'b1;
            link.shift_clock <= 1'b1;
            link.shift_data_line <= 1'b0;
        end else begin
            unique case (state)
                ST_POWER: begin
                    cnt <= cnt + 32'h1;
                    if (cnt >= 32'(POWER_ON_CYCLES)) begin
                        state <= ST_IDLE;
                        cnt <= 32'h0;
                    end
                end
                ST_IDLE: begin
                    link.reset_pin <= parallel;
                    if (reset_req && !parallel) begin
                        state <= ST_RESET;
                        link.reset_pin <= 1'b1;
                        cnt <= 32'h0;
                    end else if (start_req && !parallel) begin
                        state <= ST_LOW;
                        link.serial_select_low <= 1'b0;
                        link.shift_data_line <= word[15];
                        bits <= 5'h00;
                        cnt <= 32'(ascr_pkg::SHIFT_HALF_CYC - 1);
                    end
                end
                ST_RESET: begin
                    cnt <= cnt + 32'h1;
                    if (cnt >= 32'(ascr_pkg::RESET_PULSE_CYC - 1)) begin
                        link.reset_pin <= 1'b0;
                        reset_done <= 1'b1;
                        state <= ST_GAP;
                        cnt <= 32'h0;
                    end
                end
                ST_GAP: begin
                    cnt <= cnt + 32'h1;
                    if (cnt >= 32'(ascr_pkg::WRITE_DELAY_CYC)) begin
                        state <= ST_IDLE;
                    end
                end
                ST_LOW: begin // Clock high half with data set up
                    if (cnt == 32'h0) begin
                        link.shift_clock <= 1'b0; // falling edge samples
                        state <= ST_HIGH;
                        cnt <= 32'(ascr_pkg::SHIFT_HALF_CYC - 1);
                    end else begin
                        cnt <= cnt - 32'h1;
                    end
                end
                ST_HIGH: begin
                    if (cnt == 32'h0) begin
                        link.shift_clock <= 1'b1;
                        bits <= bits + 5'h01;
                        link.shift_data_line <= word[14];
                        cnt <= 32'(ascr_pkg::SHIFT_HALF_CYC - 1);
                        state <= (bits == 5'h0F) ? ST_END : ST_LOW;
                    end else begin
                        cnt <= cnt - 32'h1;
                    end
                end
                ST_END: begin // Select hold then release
                    if (cnt == 32'h0) begin
                        link.serial_select_low <= 1'b1;
                        words_sent <= words_sent + 8'h01;
                        state <= ST_IDLE;
                    end else begin
                        cnt <= cnt - 32'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule : ascr_host

// >>> verification/ascr_monitor.sv
// Checker: wire-level timing and framing of the serial configuration link
`timescale 1ns/100ps
module ascr_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic reset_pin,
    input wire logic serial_select_low,
    input wire logic shift_clock,
    input wire logic shift_data_line
);
    logic clk_d;
    logic [4:0] n_fall;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Counts falling shift edges within one select frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_d <= 1'b1;
            n_fall <= 5'h00;
        end else begin
            clk_d <= shift_clock;
            if (serial_select_low) n_fall <= 5'h00;
            else if (clk_d && !shift_clock) n_fall <= n_fall + 5'h01;
        end
    end
    a_pulse_min: assert property ($rose(reset_pin) |=> reset_pin)
        else $error("reset pulse too short");
    a_reset_gap: assert property (
        $fell(reset_pin) |-> serial_select_low [*3])
        else $error("select active too soon after reset");
    a_select_reset: assert property (
        !serial_select_low |-> !reset_pin)
        else $error("select active while reset pin high");
    a_select_setup: assert property (
        $fell(serial_select_low) |-> shift_clock [*3])
        else $error("shift clock fell too soon after select");
    a_data_setup: assert property (
        $fell(shift_clock) && !serial_select_low |->
        shift_data_line == $past(shift_data_line, 3))
        else $error("data changed too close to falling edge");
    a_data_hold: assert property (
        $fell(shift_clock) && !serial_select_low |=>
        $stable(shift_data_line) [*2])
        else $error("data changed too soon after falling edge");
    a_word_length: assert property (
        $rose(serial_select_low) |-> n_fall == 5'h10)
        else $error("frame is not sixteen bits");
    a_select_hold: assert property (
        $rose(serial_select_low) |-> !$past(serial_select_low, 3))
        else $error("select released too soon");
endmodule : ascr_monitor

// >>> verification/adc_serial_config_regs_bench.sv
// Testbench: host and device ends joined, driven over AHB-Lite
`timescale 1ns/100ps
module adc_serial_config_regs_bench;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic standby, clk_out_pdn, ref_external, ddr_outputs, coarse_gain;
    logic obuf_pdn, data_pos_late, clk_capture_fall, clk_pos_delay;
    logic lane_bytewise, straight_binary;
    logic [2:0] pattern_sel;
    logic [13:0] pattern_word;
    logic [10:0] user_pattern_lo, trim_gain_pattern_hi;
    logic [10:0] diff_output_setup, se_drive_setup;
    logic [10:0] m [0:31];
    int n_fail, n_tests;
    ascr_if ascr_if_i ();
    ascr_host #(.POWER_ON_CYCLES(10)) ascr_host_i (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .link(ascr_if_i.host));
    ascr_device ascr_device_i (.hclk(hclk), .hresetn(hresetn),
        .link(ascr_if_i.device), .standby(standby),
        .clk_out_pdn(clk_out_pdn), .ref_external(ref_external),
        .ddr_outputs(ddr_outputs), .coarse_gain(coarse_gain),
        .obuf_pdn(obuf_pdn), .data_pos_late(data_pos_late),
        .clk_capture_fall(clk_capture_fall), .clk_pos_delay(clk_pos_delay),
        .lane_bytewise(lane_bytewise), .straight_binary(straight_binary),
        .pattern_sel(pattern_sel), .pattern_word(pattern_word),
        .user_pattern_lo(user_pattern_lo),
        .trim_gain_pattern_hi(trim_gain_pattern_hi),
        .diff_output_setup(diff_output_setup),
        .se_drive_setup(se_drive_setup));
    ascr_monitor ascr_monitor_i (.hclk(hclk), .hresetn(hresetn),
        .reset_pin(ascr_if_i.reset_pin),
        .serial_select_low(ascr_if_i.serial_select_low),
        .shift_clock(ascr_if_i.shift_clock),
        .shift_data_line(ascr_if_i.shift_data_line));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task close_out;
        if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One single AHB-Lite word transfer, address then data phase
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task wait_idle;
        do ahb(1'b0, ascr_pkg::HOST_STATUS, 32'h0);
        while (rd[ascr_pkg::HS_BUSY] !== 1'b0);
    endtask : wait_idle
    function automatic logic [10:0] mask_of(input logic [4:0] a);
        case (a)
            5'h00: return ascr_pkg::MASK_MAIN & 11'h7EF;
            5'h04: return ascr_pkg::MASK_CLKPOS;
            5'h09: return ascr_pkg::MASK_LANE;
            5'h0A: return ascr_pkg::MASK_FMT;
            5'h0B, 5'h0C, 5'h0E, 5'h0F: return ascr_pkg::MASK_FULL;
            default: return 11'h000;
        endcase
    endfunction : mask_of
    // Sends one word through the host and updates the register model
    task send(input logic [4:0] a, input logic [10:0] d);
        ahb(1'b1, ascr_pkg::HOST_WORD, {16'h0000, a, d});
        ahb(1'b1, ascr_pkg::HOST_CTRL, 32'h1);
        wait_idle();
        repeat (4) @(posedge hclk);
        if (a == 5'h00 && d[4]) begin
            foreach (m[i]) m[i] = 11'h000;
        end else m[a] = d & mask_of(a);
    endtask : send
    task check_all;
        chk({5'h00, obuf_pdn, coarse_gain, ddr_outputs, 2'h0, ref_external,
            2'h0, clk_out_pdn, 1'b0, standby}, {5'h00, m[0]});
        chk({5'h00, data_pos_late, clk_capture_fall, clk_pos_delay, 8'h00},
            {5'h00, m[4]});
        chk({5'h00, lane_bytewise, 10'h000}, {5'h00, m[9]});
        chk({5'h00, straight_binary, 2'h0, pattern_sel, 5'h00},
            {5'h00, m[10]});
        chk({5'h00, user_pattern_lo}, {5'h00, m[11]});
        chk({5'h00, trim_gain_pattern_hi}, {5'h00, m[12]});
        chk({5'h00, diff_output_setup}, {5'h00, m[14]});
        chk({5'h00, se_drive_setup}, {5'h00, m[15]});
        if (m[10][7:5] != 3'h3) chk({2'h0, pattern_word},
            (m[10][7:5] == 3'h2) ? 16'h3FFF : 16'h0000);
    endtask : check_all
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_fields;
        logic [15:0] tbl [10];
        tbl = '{{5'h00, 11'h705}, {5'h00, 11'h020}, {5'h04, 11'h700},
            {5'h09, 11'h400}, {5'h0B, 11'h5A5}, {5'h0C, 11'h2AA},
            {5'h0E, 11'h7FF}, {5'h0F, 11'h0F0}, {5'h01, 11'h7FF},
            {5'h1F, 11'h7FF}};
        foreach (tbl[i]) begin
            send(tbl[i][15:11], tbl[i][10:0]);
            check_all();
        end
    endtask : t_fields
    task t_pattern;
        logic [13:0] p0;
        for (int c = 0; c < 4; c++) begin
            send(5'h0A, {c[0], 2'h0, c[2:0], 5'h00});
            check_all();
        end
        @(posedge hclk);
        p0 = pattern_word;
        @(posedge hclk);
        chk({15'h0000, (p0 ^ pattern_word) === 14'h3FFF &&
            (p0 === 14'h2AAA || p0 === 14'h1555)}, 16'h0001);
    endtask : t_pattern
    task t_inits;
        send(5'h00, 11'h010);
        check_all();
        send(5'h04, 11'h700);
        ahb(1'b1, ascr_pkg::HOST_CTRL, 32'h2);
        wait_idle();
        foreach (m[i]) m[i] = 11'h000;
        check_all();
        chk({15'h0000, rd[ascr_pkg::HS_RESET_DONE]}, 16'h0001);
        send(5'h00, 11'h200);
        check_all();
    endtask : t_inits
    task t_parallel;
        send(5'h09, 11'h400);
        ahb(1'b1, ascr_pkg::HOST_CTRL, 32'h4);
        ahb(1'b0, ascr_pkg::HOST_CTRL, 32'h0);
        chk({14'h0000, hresp, rd[ascr_pkg::HC_PARALLEL]}, 16'h0001);
        ahb(1'b1, ascr_pkg::HOST_WORD, {16'h0000, 5'h09, 11'h000});
        ahb(1'b1, ascr_pkg::HOST_CTRL, 32'h5);
        repeat (300) @(posedge hclk);
        chk({15'h0000, ascr_if_i.reset_pin}, 16'h0001);
        check_all();
    endtask : t_parallel
    // ------------------------------------------------------------------
    // Clock, sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        n_fail = 0;
        n_tests = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        foreach (m[i]) m[i] = 11'h000;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        wait_idle();
        check_all();
        t_fields();
        t_pattern();
        t_inits();
        ahb(1'b0, 8'h10, 32'h0);
        chk(rd[15:0], 16'h0000);
        t_parallel();
        close_out();
    end
    initial begin
        #600000;
        n_fail = n_fail + 1;
        close_out();
    end
endmodule : adc_serial_config_regs_bench
